// *** verilog/dn_err_pkg.sv ***
package dn_err_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PRI_STS = 8'h04;
    localparam logic [7:0] OFS_SEC_STS = 8'h08;
    localparam logic [7:0] OFS_UNC_STS = 8'h0C;
    localparam logic [7:0] OFS_UNC_MASK = 8'h10;
    localparam logic [7:0] OFS_UNC_SEV = 8'h14;
    localparam logic [7:0] OFS_PTR = 8'h18;
    localparam logic [7:0] OFS_HDR0 = 8'h1C;
    localparam logic [7:0] OFS_HDR1 = 8'h20;
    localparam logic [7:0] OFS_HDR2 = 8'h24;
    localparam logic [7:0] OFS_HDR3 = 8'h28;
    localparam logic [7:0] OFS_INT_MASK = 8'h2C;
    // Control fields
    localparam int CTL_PAR_RESP = 0;
    localparam int CTL_SYSTEM_ERROR_REPORT_ENABLE = 1;
    localparam int CTL_FATAL_EN = 2;
    localparam int CTL_NONFATAL_EN = 3;
    localparam int CTL_MA_MODE = 4;
    localparam int CTL_W = 5;
    // Primary status fields
    localparam int PRI_DET_PAR = 0;
    localparam int PRI_SIG_SERR = 1;
    localparam int PRI_FATAL_DET = 2;
    localparam int PRI_NONFATAL_DET = 3;
    localparam int PRI_W = 4;
    // Secondary status fields
    localparam int SEC_MST_PAR = 0;
    localparam int SEC_SIG_SERR = 1;
    localparam int SEC_RCV_MA = 2;
    localparam int SEC_W = 3;
    // Secondary uncorrectable events, also the pointer codes
    localparam int EV_UDE = 0;
    localparam int EV_PERR = 1;
    localparam int EV_SERR = 2;
    localparam int EV_MA = 3;
    localparam int EV_W = 4;
    localparam int PTR_W = 2;
    localparam int PTR_VALID = 8;
    localparam int HDR_W = 128;
    // Reset values
    localparam logic [CTL_W-1:0] CTRL_RST = 5'h00;
    localparam logic [EV_W-1:0] MASK_RST = 4'h0;
    localparam logic [EV_W-1:0] SEV_RST = 4'h0;
    // Completion status codes
    localparam logic [2:0] CPL_SC = 3'h0;
    localparam logic [2:0] CPL_UR = 3'h1;
    localparam logic [2:0] CPL_CA = 3'h4;

    typedef enum logic [1:0] {KIND_READ, KIND_NP_WRITE, KIND_POSTED} xact_kind_t;
    typedef enum logic {ST_IDLE, ST_BUSY} xact_state_t;

    typedef struct packed {
        logic start;
        xact_kind_t kind;
        logic [HDR_W-1:0] header;
    } xact_req_t;

    typedef struct packed {
        logic done;
        logic data_xfer;
        logic master_abort;
        logic target_abort;
        logic rd_data_err;
    } xact_term_t;

    typedef struct packed {
        logic valid;
        logic [2:0] status;
        logic poisoned;
    } cpl_t;

    typedef struct packed {
        logic fatal;
        logic nonfatal;
    } err_msg_t;
endpackage : dn_err_pkg

// *** verilog/dn_err_handler.sv ***
// The strobed register port and the address map were decided locally.
`timescale 1ns/100ps
// How it works
// - Read data error sets detected parity; with parity response, master parity and PERR#.
// - After a read data error keep fetching until byte count or target end.
// - Read with data error completes successfully but poisoned.
// - Unmasked error with no valid pointer logs header and sets pointer.
// - Unmasked reported error sends fatal or nonfatal message by severity and enables.
// - Sent message with system error reporting on sets signaled system error.
// - Each handled error sets fatal or nonfatal detected by severity.
// - PERR# on non-posted write completed with data returns Unsupported Request.
// - PERR# on a forwarded write sets PERR seen; with parity response, master parity.
// - PERR# on posted write: keep delivering the rest of the write.
// - Targets signal SERR#; keep forwarding, set secondary system error and SERR seen.
// - SERR# error logs no header but still updates the pointer.
// - Posted write master-abort discards write and sets both master-abort flags.
// - Posted master-abort reports when unmasked or master-abort mode set.
// - Non-posted master-abort returns Unsupported Request and sets both flags.
// - Non-posted target-abort returns Completer Abort.
module dn_err_handler
    import dn_err_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [7:0] i_addr,
    input wire logic [31:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rdata,
    input wire xact_req_t i_req,
    input wire xact_term_t i_term,
    input wire logic i_parity_error_pin_n,
    input wire logic i_system_error_pin_n,
    output logic o_parity_error_pin_n,
    output logic o_parity_error_pin_oe,
    output cpl_t o_cpl,
    output err_msg_t o_msg,
    output logic o_keep_fetching,
    output logic o_continue_write,
    output logic o_discard,
    output logic o_irq
);
    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    logic perr_meta_reg, perr_sync_reg, perr_last_reg;
    logic serr_meta_reg, serr_sync_reg, serr_last_reg;
    logic perr_fall, serr_fall;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            perr_meta_reg <= 1'b1;
            perr_sync_reg <= 1'b1;
            perr_last_reg <= 1'b1;
            serr_meta_reg <= 1'b1;
            serr_sync_reg <= 1'b1;
            serr_last_reg <= 1'b1;
        end else begin
            perr_meta_reg <= i_parity_error_pin_n;
            perr_sync_reg <= perr_meta_reg;
            perr_last_reg <= perr_sync_reg;
            serr_meta_reg <= i_system_error_pin_n;
            serr_sync_reg <= serr_meta_reg;
            serr_last_reg <= serr_sync_reg;
        end
    end

    // Edges only, so a pin held low counts as one error
    assign perr_fall = perr_last_reg & ~perr_sync_reg;
    assign serr_fall = serr_last_reg & ~serr_sync_reg;

    // ************************************************************
    // Transaction tracking
    // ************************************************************
    xact_state_t state_reg;
    xact_kind_t kind_reg;
    logic [HDR_W-1:0] header_reg;
    logic data_err_reg, perr_seen_reg, busy, term_any, np_busy;

    assign busy = (state_reg == ST_BUSY);
    assign np_busy = busy && (kind_reg != KIND_POSTED);
    assign term_any = i_term.done | i_term.master_abort | i_term.target_abort;

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            kind_reg <= KIND_READ;
            header_reg <= '0;
        end else if (!busy && i_req.start) begin
            state_reg <= ST_BUSY;
            kind_reg <= i_req.kind;
            header_reg <= i_req.header;
        end else if (busy && term_any) begin
            state_reg <= ST_IDLE;
        end
    end

    // ************************************************************
    // Error events
    // ************************************************************
    logic [EV_W-1:0] ev, elig, rep;
    logic [CTL_W-1:0] ctrl_reg;
    logic [EV_W-1:0] unc_mask_reg, unc_sev_reg;

    assign ev[EV_UDE] = busy && kind_reg == KIND_READ && i_term.rd_data_err;
    assign ev[EV_PERR] = busy && kind_reg != KIND_READ && perr_fall;
    assign ev[EV_SERR] = busy && serr_fall;
    assign ev[EV_MA] = busy && i_term.master_abort;

    generate
        for (genvar i = 0; i < EV_W; i++) begin : g_report
            // Master-abort mode forces reporting of a masked posted abort only
            assign elig[i] = ev[i] & (~unc_mask_reg[i] | ((i == EV_MA) & ctrl_reg[CTL_MA_MODE] &
                (kind_reg == KIND_POSTED)));
            assign rep[i] = elig[i] & (ctrl_reg[CTL_SYSTEM_ERROR_REPORT_ENABLE] |
                (unc_sev_reg[i] ? ctrl_reg[CTL_FATAL_EN] : ctrl_reg[CTL_NONFATAL_EN]));
        end
    endgenerate

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            data_err_reg <= 1'b0;
            perr_seen_reg <= 1'b0;
            o_keep_fetching <= 1'b0;
            o_continue_write <= 1'b0;
        end else if (!busy || term_any) begin
            data_err_reg <= 1'b0;
            perr_seen_reg <= 1'b0;
            o_keep_fetching <= 1'b0;
            o_continue_write <= 1'b0;
        end else begin
            if (ev[EV_UDE]) begin
                data_err_reg <= 1'b1;
                o_keep_fetching <= 1'b1;
            end
            if (ev[EV_PERR]) begin
                perr_seen_reg <= 1'b1;
                o_continue_write <= (kind_reg == KIND_POSTED);
            end
        end
    end

    // ************************************************************
    // Completions, discard and PERR# drive
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_cpl <= '0;
            o_discard <= 1'b0;
        end else begin
            o_cpl <= '0;
            o_discard <= busy && kind_reg == KIND_POSTED && i_term.master_abort;
            if (np_busy && i_term.master_abort) begin
                o_cpl <= '{valid: 1'b1, status: CPL_UR, poisoned: 1'b0};
            end else if (np_busy && i_term.target_abort) begin
                o_cpl <= '{valid: 1'b1, status: CPL_CA, poisoned: 1'b0};
            end else if (np_busy && i_term.done && kind_reg == KIND_READ) begin
                o_cpl <= '{valid: 1'b1, status: CPL_SC,
                    poisoned: data_err_reg | ev[EV_UDE]};
            end else if (np_busy && i_term.done) begin
                o_cpl.valid <= 1'b1;
                o_cpl.status <= ((perr_seen_reg | ev[EV_PERR]) && i_term.data_xfer) ?
                    CPL_UR : CPL_SC;
            end
        end
    end

    // Bridge drives PERR# for one cycle per read data error it detects, only while parity response is on
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_parity_error_pin_n <= 1'b1;
            o_parity_error_pin_oe <= 1'b0;
        end else begin
            o_parity_error_pin_n <= ~(ev[EV_UDE] & ctrl_reg[CTL_PAR_RESP]);
            o_parity_error_pin_oe <= ev[EV_UDE] & ctrl_reg[CTL_PAR_RESP];
        end
    end

    // ************************************************************
    // Status registers
    // ************************************************************
    logic [PRI_W-1:0] pri_sts_reg, pri_set;
    logic [SEC_W-1:0] sec_sts_reg, sec_set;
    logic [EV_W-1:0] unc_sts_reg, int_mask_reg;
    logic wr_pri, wr_sec, wr_unc;

    assign wr_pri = i_wr && i_addr == OFS_PRI_STS;
    assign wr_sec = i_wr && i_addr == OFS_SEC_STS;
    assign wr_unc = i_wr && i_addr == OFS_UNC_STS;

    assign pri_set[PRI_DET_PAR] = ev[EV_UDE];
    assign pri_set[PRI_SIG_SERR] = (|rep) & ctrl_reg[CTL_SYSTEM_ERROR_REPORT_ENABLE];
    assign pri_set[PRI_FATAL_DET] = |(ev & unc_sev_reg);
    assign pri_set[PRI_NONFATAL_DET] = |(ev & ~unc_sev_reg);
    assign sec_set[SEC_MST_PAR] = (ev[EV_UDE] | ev[EV_PERR]) & ctrl_reg[CTL_PAR_RESP];
    assign sec_set[SEC_SIG_SERR] = ev[EV_SERR];
    assign sec_set[SEC_RCV_MA] = ev[EV_MA];

    // Set wins over a same-cycle write-one clear
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            pri_sts_reg <= '0;
            sec_sts_reg <= '0;
            unc_sts_reg <= '0;
        end else begin
            pri_sts_reg <= (pri_sts_reg & ~(wr_pri ? i_wdata[PRI_W-1:0] : '0)) | pri_set;
            sec_sts_reg <= (sec_sts_reg & ~(wr_sec ? i_wdata[SEC_W-1:0] : '0)) | sec_set;
            unc_sts_reg <= (unc_sts_reg & ~(wr_unc ? i_wdata[EV_W-1:0] : '0)) | ev;
        end
    end

    // ************************************************************
    // First-error pointer and header log
    // ************************************************************
    logic [PTR_W-1:0] ptr_reg, ptr_pick;
    logic ptr_valid_reg;
    logic [HDR_W-1:0] hdr_log_reg;
    logic [EV_W-1:0] unmasked;

    assign unmasked = ev & ~unc_mask_reg;

    // Lowest index wins when several errors land together
    always_comb begin
        ptr_pick = '0;
        for (int i = EV_W - 1; i >= 0; i--) begin
            if (unmasked[i]) begin
                ptr_pick = PTR_W'(i);
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ptr_reg <= '0;
            ptr_valid_reg <= 1'b0;
            hdr_log_reg <= '0;
        end else if (!ptr_valid_reg && |unmasked) begin
            ptr_reg <= ptr_pick;
            ptr_valid_reg <= 1'b1;
            if (ptr_pick != PTR_W'(EV_SERR)) begin
                hdr_log_reg <= header_reg;
            end
        end else if (wr_unc && i_wdata[ptr_reg] && !ev[ptr_reg]) begin
            ptr_valid_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Messages and interrupt
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_msg <= '0;
            o_irq <= 1'b0;
        end else begin
            o_msg.fatal <= |(rep & unc_sev_reg);
            o_msg.nonfatal <= |(rep & ~unc_sev_reg);
            o_irq <= |(unc_sts_reg & int_mask_reg);
        end
    end

    // ************************************************************
    // Register port
    // ************************************************************
    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            ctrl_reg <= CTRL_RST;
            unc_mask_reg <= MASK_RST;
            unc_sev_reg <= SEV_RST;
            int_mask_reg <= MASK_RST;
        end else if (i_wr) begin
            unique case (i_addr)
                OFS_CTRL: ctrl_reg <= i_wdata[CTL_W-1:0];
                OFS_UNC_MASK: unc_mask_reg <= i_wdata[EV_W-1:0];
                OFS_UNC_SEV: unc_sev_reg <= i_wdata[EV_W-1:0];
                OFS_INT_MASK: int_mask_reg <= i_wdata[EV_W-1:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= '0;
        end else begin
            o_rdata <= '0;
            if (i_rd) begin
                unique case (i_addr)
                    OFS_CTRL: o_rdata <= 32'(ctrl_reg);
                    OFS_PRI_STS: o_rdata <= 32'(pri_sts_reg);
                    OFS_SEC_STS: o_rdata <= 32'(sec_sts_reg);
                    OFS_UNC_STS: o_rdata <= 32'(unc_sts_reg);
                    OFS_UNC_MASK: o_rdata <= 32'(unc_mask_reg);
                    OFS_UNC_SEV: o_rdata <= 32'(unc_sev_reg);
                    OFS_PTR: o_rdata <= 32'({ptr_valid_reg, 6'h00, ptr_reg});
                    OFS_HDR0: o_rdata <= hdr_log_reg[31:0];
                    OFS_HDR1: o_rdata <= hdr_log_reg[63:32];
                    OFS_HDR2: o_rdata <= hdr_log_reg[95:64];
                    OFS_HDR3: o_rdata <= hdr_log_reg[127:96];
                    OFS_INT_MASK: o_rdata <= 32'(int_mask_reg);
                    default: o_rdata <= '0;
                endcase
            end
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);

    sequence s_np_ma;
        np_busy && i_term.master_abort;
    endsequence
    sequence s_ur_cpl;
        o_cpl.valid && o_cpl.status == CPL_UR;
    endsequence

    a_read_perr_drive: assert property (ev[EV_UDE] && ctrl_reg[CTL_PAR_RESP] |=>
        !o_parity_error_pin_n && o_parity_error_pin_oe && sec_sts_reg[SEC_MST_PAR]
        ##1 !o_parity_error_pin_oe || $past(ev[EV_UDE]))
        else $error("PERR drive on read error wrong");
    a_keep_fetch: assert property (ev[EV_UDE] && !term_any |=> o_keep_fetching)
        else $error("keep fetching not raised");
    a_poison_cpl: assert property (np_busy && kind_reg == KIND_READ && i_term.done &&
        !i_term.master_abort && !i_term.target_abort && data_err_reg |=>
        o_cpl.valid && o_cpl.status == CPL_SC && o_cpl.poisoned)
        else $error("read error completion not poisoned");
    a_ude_flags: assert property (ev[EV_UDE] |=> unc_sts_reg[EV_UDE] && pri_sts_reg[PRI_DET_PAR])
        else $error("data error flags not set");
    a_ptr_capture: assert property (!ptr_valid_reg && unmasked != '0 |=>
        ptr_valid_reg && ptr_reg == $past(ptr_pick))
        else $error("first error pointer not captured");
    a_serr_nolog: assert property (!ptr_valid_reg && unmasked == (EV_W'(1) << EV_SERR) |=>
        ptr_valid_reg && $stable(hdr_log_reg))
        else $error("header logged on SERR");
    a_msg_fatal: assert property ((rep & unc_sev_reg) != '0 |=> o_msg.fatal)
        else $error("fatal message missing");
    a_sig_serr: assert property (rep != '0 && ctrl_reg[CTL_SYSTEM_ERROR_REPORT_ENABLE] |=>
        pri_sts_reg[PRI_SIG_SERR])
        else $error("signaled system error not set");
    a_np_perr_ur: assert property (np_busy && kind_reg == KIND_NP_WRITE && perr_seen_reg &&
        i_term.done && i_term.data_xfer && !i_term.master_abort && !i_term.target_abort
        |=> s_ur_cpl)
        else $error("non-posted PERR did not return UR");
    a_perr_seen: assert property (ev[EV_PERR] |=> unc_sts_reg[EV_PERR])
        else $error("PERR seen flag not set");
    a_serr_flags: assert property (ev[EV_SERR] |=>
        sec_sts_reg[SEC_SIG_SERR] && unc_sts_reg[EV_SERR])
        else $error("SERR flags not set");
    a_posted_discard: assert property (busy && kind_reg == KIND_POSTED && i_term.master_abort
        |=> o_discard && !o_cpl.valid && sec_sts_reg[SEC_RCV_MA] && unc_sts_reg[EV_MA])
        else $error("posted master-abort handling wrong");
    a_np_ma_ur: assert property (s_np_ma |=> s_ur_cpl)
        else $error("master-abort completion not UR");
    a_ta_ca: assert property (np_busy && i_term.target_abort && !i_term.master_abort
        |=> o_cpl.valid && o_cpl.status == CPL_CA)
        else $error("target-abort completion not CA");
    a_flag_sticky: assert property (pri_sts_reg[PRI_DET_PAR] &&
        !(wr_pri && i_wdata[PRI_DET_PAR]) |=> pri_sts_reg[PRI_DET_PAR])
        else $error("status flag lost without clear");
    a_np_ma_quiet: assert property (np_busy && i_term.master_abort && unc_mask_reg[EV_MA] &&
        ev == (EV_W'(1) << EV_MA) |=> !o_msg.fatal && !o_msg.nonfatal)
        else $error("masked non-posted abort reported");
    a_write_continue: assert property (ev[EV_PERR] && kind_reg == KIND_POSTED
        && !term_any |=> o_continue_write)
        else $error("posted write not continued after PERR");
    a_np_ma_flags: assert property (s_np_ma |=>
        sec_sts_reg[SEC_RCV_MA] && unc_sts_reg[EV_MA])
        else $error("master-abort flags not set");
endmodule : dn_err_handler

// *** verification/pci_target_model.sv ***
`timescale 1ns/100ps
module pci_target_model
    import dn_err_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_go,
    input wire logic [1:0] i_mode,
    input wire logic i_rd_err,
    input wire logic i_perr,
    input wire logic i_serr,
    input wire logic [2:0] i_dly,
    output xact_term_t o_term,
    output logic o_perr_n,
    output logic o_serr_n,
    output logic o_busy
);
    // ****************************************
    // Target side of one forwarded transaction
    // ****************************************
    initial begin
        o_term = '0;
        o_perr_n = 1'b1;
        o_serr_n = 1'b1;
        o_busy = 1'b0;
        forever begin
            @(posedge i_sys_clk);
            if (i_go) begin
                o_busy <= 1'b1;
                @(posedge i_sys_clk);
                o_term.rd_data_err <= i_rd_err;
                @(posedge i_sys_clk);
                o_term.rd_data_err <= 1'b0;
                o_perr_n <= !i_perr;
                o_serr_n <= !i_serr;
                repeat (2) @(posedge i_sys_clk);
                // Released pins float back high through the bus pull-ups
                o_perr_n <= 1'b1;
                o_serr_n <= 1'b1;
                // Slow targets: the pin must be seen before the end
                repeat (4 + i_dly) @(posedge i_sys_clk);
                o_term.done <= i_mode < 2'h2;
                o_term.data_xfer <= i_mode == 2'h0;
                o_term.master_abort <= i_mode == 2'h2;
                o_term.target_abort <= i_mode == 2'h3;
                @(posedge i_sys_clk);
                o_term <= '0;
                o_busy <= 1'b0;
            end
        end
    end
endmodule : pci_target_model

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import dn_err_pkg::*;
    logic i_sys_clk, i_rst, i_wr, i_rd, go, rde, pe, se, perr_n, serr_n, mbusy;
    logic o_pe_n, o_pe_oe, o_keep_fetching, o_continue_write, o_discard, o_irq;
    logic s_oe, s_keep, s_cont, s_disc, fat, nf, sig;
    logic [7:0] i_addr;
    logic [31:0] i_wdata, o_rdata, d, lp;
    logic [1:0] mode, kind;
    logic [2:0] dly;
    logic [3:0] msk, sev, imsk, unc, lg, rep, n_cpl;
    logic [4:0] ctrl;
    logic [127:0] hdr;
    xact_req_t req;
    xact_term_t term;
    cpl_t o_cpl, cpl_got;
    err_msg_t o_msg, msg_got;
    int n_fail = 0;
    int n_compared = 0;
    wire perr_wire = perr_n & !(o_pe_oe && !o_pe_n);

    initial begin
        i_sys_clk = 1'b0;
        forever #25 i_sys_clk = !i_sys_clk;
    end

    dn_err_handler DUT (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_req(req),
        .i_term(term), .i_parity_error_pin_n(perr_wire), .i_system_error_pin_n(serr_n),
        .o_parity_error_pin_n(o_pe_n), .o_parity_error_pin_oe(o_pe_oe), .o_cpl(o_cpl),
        .o_msg(o_msg), .o_keep_fetching(o_keep_fetching), .o_continue_write(o_continue_write),
        .o_discard(o_discard), .o_irq(o_irq));
    pci_target_model target (.i_sys_clk(i_sys_clk), .i_go(go), .i_mode(mode),
        .i_rd_err(rde), .i_perr(pe), .i_serr(se), .i_dly(dly), .o_term(term),
        .o_perr_n(perr_n), .o_serr_n(serr_n), .o_busy(mbusy));

    // ****************************************
    // Output monitor: pulses are latched here
    // ****************************************
    always @(posedge i_sys_clk) begin
        if (o_pe_oe && !o_pe_n) s_oe <= 1'b1;
        if (o_keep_fetching) s_keep <= 1'b1;
        if (o_continue_write) s_cont <= 1'b1;
        if (o_discard) s_disc <= 1'b1;
        if (o_cpl.valid) n_cpl <= n_cpl + 4'h1;
        if (o_cpl.valid) cpl_got <= o_cpl;
        if (o_msg != '0) msg_got <= msg_got | o_msg;
    end

    // ****************************************
    // Bus tasks and expectations
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_sys_clk);
        i_wr <= 1'b0;
        @(posedge i_sys_clk);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_sys_clk);
        i_rd <= 1'b0;
        @(negedge i_sys_clk);
        d = o_rdata;
        chk(d, e);
        @(posedge i_sys_clk);
    endtask : rchk
    function automatic logic [31:0] ptr_exp(input logic [3:0] l);
        for (int k = 0; k < EV_W; k++) begin
            if (l[k]) return (32'h1 << PTR_VALID) | 32'(k);
        end
        return 32'h0;
    endfunction : ptr_exp
    function automatic logic [2:0] cpl_exp();
        if (mode == 2'h2) return CPL_UR;
        if (mode == 2'h3) return CPL_CA;
        if (kind == KIND_NP_WRITE && pe && mode == 2'h0) return CPL_UR;
        return CPL_SC;
    endfunction : cpl_exp
    task automatic conclude();
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        i_rst = 1'b1;
        {i_wr, i_rd, go, rde, pe, se, i_addr, i_wdata, mode, dly, kind} = '0;
        req = '0;
        lp = '0;
        void'($urandom(32'hF60EE3ED));
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        @(posedge i_sys_clk);
        for (int a = 0; a <= 'h2C; a += 4) rchk(8'(a), 32'h0);
        rchk(8'hFC, 32'h0);
        wr(OFS_CTRL, 32'hFFFFFFFF);
        rchk(OFS_CTRL, 32'h1F);
        wr(OFS_PTR, 32'hFFFFFFFF);
        rchk(OFS_PTR, 32'h0);
        for (int i = 0; i < 40; i++) begin
            {ctrl, msk, sev, imsk, dly} = {$urandom, $urandom};
            kind = 2'($urandom_range(2));
            mode = 2'($urandom);
            rde = kind == KIND_READ && $urandom_range(1);
            pe = kind != KIND_READ && $urandom_range(1);
            se = 1'($urandom);
            hdr = {$urandom, $urandom, $urandom, $urandom};
            if (rde || pe) mode[1] = 1'b0;
            if (kind == KIND_POSTED && mode == 2'h3) mode = 2'h2;
            // Hand-picked corners come first
            case (i)
                0: {kind, rde, pe, se, mode, ctrl, msk, sev} = {2'h0, 3'h4, 2'h0, 5'h1F, 8'h01};
                1: {kind, rde, pe, se, mode, ctrl, msk, sev} = {2'h1, 3'h2, 2'h1, 5'h01, 8'h00};
                2: {kind, rde, pe, se, mode, ctrl, msk, sev} = {2'h2, 3'h0, 2'h2, 5'h12, 8'hF8};
                3: {kind, rde, pe, se, mode, ctrl, msk, sev} = {2'h1, 3'h1, 2'h3, 5'h0A, 8'h00};
                4: {kind, rde, pe, se, mode, ctrl, msk, sev} = {2'h2, 3'h3, 2'h0, 5'h0F, 8'h06};
                5: {kind, rde, pe, se, mode, ctrl, msk, sev} = {2'h1, 3'h2, 2'h0, 5'h03, 8'h02};
                default: ;
            endcase
            wr(OFS_CTRL, 32'(ctrl));
            wr(OFS_UNC_MASK, 32'(msk));
            wr(OFS_UNC_SEV, 32'(sev));
            wr(OFS_INT_MASK, 32'(imsk));
            // Cleared off the clock edge so the monitor never races it
            @(negedge i_sys_clk);
            {s_oe, s_keep, s_cont, s_disc, n_cpl, msg_got} = '0;
            @(posedge i_sys_clk);
            req <= '{1'b1, xact_kind_t'(kind), hdr};
            go <= 1'b1;
            @(posedge i_sys_clk);
            req.start <= 1'b0;
            go <= 1'b0;
            // Busy from the model lands by non-blocking assignment, so look one edge later
            @(posedge i_sys_clk);
            for (int k = 0; k < 40 && mbusy; k++) @(posedge i_sys_clk);
            if (mbusy) n_fail++;
            repeat (2) @(posedge i_sys_clk);
            unc = {mode == 2'h2, se, pe, rde};
            lg = unc & ~msk;
            rep = lg;
            if (kind == KIND_POSTED && ctrl[CTL_MA_MODE]) rep[EV_MA] = unc[EV_MA];
            fat = |(rep & sev) && (ctrl[CTL_SYSTEM_ERROR_REPORT_ENABLE] || ctrl[CTL_FATAL_EN]);
            nf = |(rep & ~sev) && (ctrl[CTL_SYSTEM_ERROR_REPORT_ENABLE] || ctrl[CTL_NONFATAL_EN]);
            sig = (fat || nf) && ctrl[CTL_SYSTEM_ERROR_REPORT_ENABLE];
            chk(32'(msg_got), {30'h0, fat, nf});
            chk({31'h0, o_irq}, {31'h0, |(unc & imsk)});
            rchk(OFS_UNC_STS, 32'(unc));
            rchk(OFS_PRI_STS, {28'h0, |(unc & ~sev), |(unc & sev), sig, rde});
            rchk(OFS_SEC_STS, {29'h0, mode == 2'h2, se, (rde || pe) && ctrl[CTL_PAR_RESP]});
            // An invalid pointer still shows the index of the last captured error
            if (lg != 4'h0) lp = ptr_exp(lg) & 32'h3;
            rchk(OFS_PTR, ptr_exp(lg) | lp);
            if (lg != 4'h0 && ptr_exp(lg) != ptr_exp(4'h4)) begin
                for (int w = 0; w < 4; w++) rchk(OFS_HDR0 + 8'(4 * w), hdr[32 * w +: 32]);
            end
            chk(32'(n_cpl), 32'(kind != KIND_POSTED));
            if (kind != KIND_POSTED) chk(32'({cpl_got.status, cpl_got.poisoned}), 32'({cpl_exp(), rde}));
            chk({28'h0, s_oe, s_keep, s_cont, s_disc}, {28'h0, rde && ctrl[CTL_PAR_RESP], rde,
                pe && kind == KIND_POSTED, mode == 2'h2 && kind == KIND_POSTED});
            chk({30'h0, o_keep_fetching, o_continue_write}, 32'h0);
            wr(OFS_PRI_STS, 32'hF);
            wr(OFS_SEC_STS, 32'h7);
            wr(OFS_UNC_STS, 32'hF);
            rchk(OFS_UNC_STS, 32'h0);
            rchk(OFS_PTR, lp);
            chk(d & ptr_exp(4'h1), 32'h0);
        end
        conclude();
    end

    initial begin
        repeat (30000) @(posedge i_sys_clk);
        n_fail++;
        conclude();
    end
endmodule : tb_top
